// File: verilog/remap_rank_regs.vh
// Constants for the channel re-mapping and shutdown rank registers
// How it works
// RULE1 - Re-mapping only permutes channels within one four-channel group.
// RULE2 - Re-mapping write ignored unless all four group channels are off.
// RULE3 - Four 2-bit fields; code 00..11 selects physical channel 1..4.
// RULE4 - Top bit pair serves logical channel 4, lower pairs lower channels.
// RULE5 - Re-mapping register powers up at 1110 0100, the identity mapping.
// RULE6 - External reset pin leaves the re-mapping register unchanged.
// RULE7 - A write with duplicate physical codes is discarded; old mapping kept.
// RULE8 - Host should run detection and classification after remap before power-on.
// RULE9 - Rank register 27h read/write, reset zero; bits 6:4 ch2, 2:0 ch1.
// RULE10 - With multi-rank enabled, rank decides turn-off on serial shutdown code.
// RULE11 - All-off and uniqueness checked on whole byte; update all or nothing.
// RULE12 - Re-mapping register reads back the mapping currently applied.
`ifndef REMAP_RANK_REGS_VH
`define REMAP_RANK_REGS_VH
`define CMD_REMAP        8'h26
`define CMD_RANK12       8'h27
`define REMAP_RESET_VAL  8'hE4
`define RANK_RESET_VAL   8'h00
`define RANK_WRITE_MASK  8'h77
`define CH1_RANK_LSB     0
`define CH2_RANK_LSB     4
`define RANK_W           3
`endif

// File: verilog/map_code_checker.v
// Checks that four 2-bit physical codes are all distinct
`timescale 1ns/1ps
`default_nettype none
module map_code_checker
(
    // Candidate mapping byte
    input  wire [7:0] code_in,
    // Result
    output wire       unique_out
);
    wire [1:0] c0 = code_in[1:0];
    wire [1:0] c1 = code_in[3:2];
    wire [1:0] c2 = code_in[5:4];
    wire [1:0] c3 = code_in[7:6];
    // Four distinct codes out of four means a true permutation
    assign unique_out = (c0 != c1) && (c0 != c2) && (c0 != c3) &&
                        (c1 != c2) && (c1 != c3) && (c2 != c3); // RULE7
endmodule // map_code_checker
`default_nettype wire

// File: verilog/channel_remap_priority_regs.v
// Re-mapping and channel 1/2 shutdown rank registers for one channel group
`timescale 1ns/1ps
`default_nettype none
`include "remap_rank_regs.vh"
module channel_remap_priority_regs
(
    // Clock and resets
    input  wire       clock_in,
    input  wire       resetn_in,
    input  wire       pin_resetn_in,
    // Command port from serial management slave
    input  wire       cmd_write_in,
    input  wire       cmd_read_in,
    input  wire [7:0] cmd_code_in,
    input  wire [7:0] cmd_data_in,
    // Group state and shutdown inputs
    input  wire [3:0] group_off_in,
    input  wire       multi_rank_enable_in,
    input  wire       serial_shutdown_valid_in,
    input  wire [2:0] serial_shutdown_input_in,
    // Read answer
    output reg  [7:0] read_data_out,
    output reg        read_valid_out,
    // Applied mapping, per logical channel, within this group only
    output reg  [7:0] logical_to_physical_map_out,
    output reg        map_write_rejected_out,
    // Shutdown requests to channels 1 and 2
    output reg  [1:0] rank_shutdown_out
);
    reg  [7:0] logical_to_physical_map_reg;
    reg  [7:0] ch12_shutdown_rank_reg;
    wire       codes_unique;
    wire       remap_hit = cmd_write_in && (cmd_code_in == `CMD_REMAP);
    wire       rank_hit  = cmd_write_in && (cmd_code_in == `CMD_RANK12);
    // Both checks are on the one written byte, so the update is all or nothing
    wire       remap_ok  = remap_hit && (&group_off_in) && codes_unique; // RULE2 RULE11
    wire [2:0] ch1_rank  = ch12_shutdown_rank_reg[`CH1_RANK_LSB +: `RANK_W];
    wire [2:0] ch2_rank  = ch12_shutdown_rank_reg[`CH2_RANK_LSB +: `RANK_W];

    map_code_checker checker_inst
    (
        .code_in    (cmd_data_in),
        .unique_out (codes_unique)
    );

    // Mapping only on the power-on reset; the pin reset must not touch it
    always @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            logical_to_physical_map_reg <= `REMAP_RESET_VAL; // RULE5
            logical_to_physical_map_out <= `REMAP_RESET_VAL;
            map_write_rejected_out      <= 1'b0;
        end
        else
        begin
            // 2-bit codes cannot leave the group by construction
            if (remap_ok)
                logical_to_physical_map_reg <= cmd_data_in; // RULE1 RULE3 RULE4 RULE6 RULE7
            logical_to_physical_map_out <= remap_ok ? cmd_data_in
                                                    : logical_to_physical_map_reg;
            map_write_rejected_out <= remap_hit && !remap_ok;
        end
    end

    // Rank register is cleared by either reset
    always @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
            ch12_shutdown_rank_reg <= `RANK_RESET_VAL; // RULE9
        else if (!pin_resetn_in)
            ch12_shutdown_rank_reg <= `RANK_RESET_VAL;
        else if (rank_hit)
            ch12_shutdown_rank_reg <= cmd_data_in & `RANK_WRITE_MASK; // RULE9
    end

    // Read answer one cycle after the request
    always @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            read_data_out  <= 8'h00;
            read_valid_out <= 1'b0;
        end
        else
        begin
            read_valid_out <= cmd_read_in;
            if (cmd_read_in)
            begin
                case (cmd_code_in)
                    `CMD_REMAP:  read_data_out <= logical_to_physical_map_reg; // RULE12
                    `CMD_RANK12: read_data_out <= ch12_shutdown_rank_reg;
                    default:     read_data_out <= 8'h00;
                endcase
            end
        end
    end

    // Channel turns off when received code is not above its rank
    always @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
            rank_shutdown_out <= 2'b00;
        else if (multi_rank_enable_in && serial_shutdown_valid_in)
            rank_shutdown_out <= {serial_shutdown_input_in <= ch2_rank,
                                  serial_shutdown_input_in <= ch1_rank}; // RULE10
        else
            rank_shutdown_out <= 2'b00;
    end
endmodule // channel_remap_priority_regs
`default_nettype wire

// File: tb/remap_host_model.sv
// Host command driver; never commands power-on, so no detection is owed after remap
`timescale 1ns/1ps
`default_nettype none
module remap_host_model(input wire clock_in, output logic wr_out = 1'h0, rd_out = 1'h0,
    output logic [7:0] code_out = 8'h00, data_out = 8'h00);
    task send(input w, input [7:0] c, e);
        @(negedge clock_in) {wr_out, rd_out, code_out, data_out} = {w, !w, c, e};
        // Inverted on release so stale data never passes
        @(negedge clock_in) {wr_out, rd_out, code_out, data_out} = {2'h0, ~c, ~e};
    endtask
endmodule // remap_host_model
`default_nettype wire

// File: tb/remap_chk_assertions.sv
// Port checks for the remap register and the read handshake
`timescale 1ns/1ps
`default_nettype none
module remap_chk(input wire clock_in, resetn_in, pin_resetn_in, cmd_write_in, cmd_read_in,
    input wire read_valid_out, map_write_rejected_out, input wire [3:0] group_off_in,
    input wire [7:0] cmd_code_in, cmd_data_in, logical_to_physical_map_out);
    wire [7:0] m = logical_to_physical_map_out, d = cmd_data_in;
    wire rj = map_write_rejected_out;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    sequence map_wr; cmd_write_in && cmd_code_in == 8'h26; endsequence
    a_read_ack: assert property (cmd_read_in |=> read_valid_out) else $error("ack");
    a_read_idle: assert property (!cmd_read_in |=> !read_valid_out) else $error("ack");
    a_busy_nak: assert property (map_wr ##0 ~&group_off_in |=> rj) else $error("busy");
    a_dup_nak: assert property (map_wr ##0 &group_off_in && d[1:0] == d[3:2] |=> rj)
        else $error("dup");
    a_byte_whole: assert property (map_wr ##0 &group_off_in |=> rj || m == $past(d))
        else $error("map");
    a_nak_hold: assert property (rj |-> $stable(m)) else $error("nak");
    a_pin_hold: assert property (!pin_resetn_in && !cmd_write_in |=> $stable(m))
        else $error("pin");
    a_boot_map: assert property ($rose(resetn_in) |-> m == 8'hE4) else $error("boot");
endmodule // remap_chk
bind channel_remap_priority_regs remap_chk u_chk(.*);
`default_nettype wire

// File: tb/tb_channel_remap_priority_regs.sv
// Scoreboard bench for remap and rank registers
`timescale 1ns/1ps
`default_nettype none
module tb_channel_remap_priority_regs;
    logic clock_in = 0, resetn_in = 0, pin_resetn_in = 1, multi_rank_enable_in = 1;
    logic serial_shutdown_valid_in = 0, cmd_write_in, cmd_read_in, read_valid_out;
    logic map_write_rejected_out;
    logic [1:0] rank_shutdown_out;
    logic [2:0] serial_shutdown_input_in = 3'h0;
    logic [3:0] group_off_in = 4'hF;
    logic [7:0] cmd_code_in, cmd_data_in, read_data_out, logical_to_physical_map_out, d, q[$];
    int fail_count = 0, checked = 0;
    always #5 clock_in = ~clock_in;
    remap_host_model host(.clock_in(clock_in), .wr_out(cmd_write_in), .rd_out(cmd_read_in),
        .code_out(cmd_code_in), .data_out(cmd_data_in));
    channel_remap_priority_regs DUT(.*);
    task complete_run;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input [7:0] seen, exp);
        checked++;
        if (seen !== exp)
            $display("ERROR %s exp %h seen %h", nm, exp, seen);
        fail_count += int'(seen !== exp);
    endtask
    task rx(input [7:0] c, e);
        q.push_back(e);
        host.send(1'h0, c, 8'h00);
    endtask
    always @(negedge clock_in)
        if (read_valid_out === 1'h1)
            chk("read_data_out", read_data_out, q.pop_front());
    initial
    begin
        d = $urandom(32'h23BF);
        repeat (6) @(negedge clock_in);
        resetn_in = 1;
        rx(8'h26, 8'hE4);
        rx(8'h27, 8'h00);
        host.send(1'h1, 8'h26, 8'h1B);
        rx(8'h26, 8'h1B);
        group_off_in = 4'hF ^ (4'h1 << d[1:0]);
        host.send(1'h1, 8'h26, 8'hE4);
        rx(8'h26, 8'h1B);
        group_off_in = 4'hF;
        host.send(1'h1, 8'h26, {d[7:2], d[3:2]});
        rx(8'h26, 8'h1B);
        host.send(1'h1, 8'h27, 8'hFF);
        rx(8'h27, 8'h77);
        host.send(1'h1, 8'h27, 8'h35);
        @(negedge clock_in) {serial_shutdown_valid_in, serial_shutdown_input_in} = {1'b1, 3'h4};
        @(negedge clock_in) serial_shutdown_valid_in = 1'b0;
        chk("rank_shutdown_out", {6'h00, rank_shutdown_out}, 8'h01);
        pin_resetn_in = 0;
        @(negedge clock_in) pin_resetn_in = 1;
        rx(8'h27, 8'h00);
        rx(8'h26, 8'h1B);
        chk("logical_to_physical_map_out", logical_to_physical_map_out, 8'h1B);
        repeat (3) @(negedge clock_in);
        complete_run;
    end
    initial
    begin
        #5000 fail_count++;
        complete_run;
    end
endmodule // tb_channel_remap_priority_regs
`default_nettype wire
